// >>> pdhs_consts.svh
`ifndef PDHS_CONSTS_SVH
`define PDHS_CONSTS_SVH

// timing figures in their own units, at a 100 MHz clock
`define PDHS_CLK_MHZ          100
`define PDHS_INRUSH_MIN_MS    80
`define PDHS_OVL_QUAL_US      140
`define PDHS_SHORT_MS         1
`define PDHS_INRUSH_CYC       (`PDHS_INRUSH_MIN_MS * 1000 * `PDHS_CLK_MHZ)
`define PDHS_OVL_QUAL_CYC     (`PDHS_OVL_QUAL_US * `PDHS_CLK_MHZ)
`define PDHS_SHORT_CYC        (`PDHS_SHORT_MS * 1000 * `PDHS_CLK_MHZ)
`define PDHS_WAIT_CYC_DEF     1000
`define PDHS_SOFTSTART_MIN    64
`define PDHS_SOFTSTART_MAX    4096
`define PDHS_CNT_W            24
`define PDHS_SS_W             13

// register map (own choice)
`define PDHS_ADDR_CTRL        12'h000
`define PDHS_ADDR_STATUS      12'h004
`define PDHS_ADDR_WAIT        12'h008
`define PDHS_CTRL_RST         32'h0000_0000
`define PDHS_CTRL_AUTO_SLEEP  0
`define PDHS_CTRL_FORCE_MPS   1

`endif

// >>> pdhs_pkg.sv
package pdhs_pkg;
  typedef enum logic [1:0] {
    PDHS_OFF      = 2'b00,
    PDHS_INRUSH   = 2'b01,
    PDHS_ON       = 2'b11,
    PDHS_OVERLOAD = 2'b10
  } pdhs_state_t;

  typedef enum logic [2:0] {
    PDHS_CL_IDLE  = 3'b000,
    PDHS_CL_EV1   = 3'b001,
    PDHS_CL_MARK1 = 3'b011,
    PDHS_CL_EV2   = 3'b010,
    PDHS_CL_MARK2 = 3'b110,
    PDHS_CL_DONE  = 3'b111
  } pdhs_class_t;
endpackage

// >>> pdhs_pse.sv
`timescale 1ns/1ps
// ************************************
// line-side source model
// ************************************
module pdhs_pse (
  input  wire logic sys_clk,
  input  wire logic invalid_signature,
  output logic      line_above_class,
  output logic      line_below_mark,
  output logic      undervoltage_lockout,
  output int        marks_invalid
);
  initial begin
    line_above_class     = 1'b0;
    line_below_mark      = 1'b0;
    undervoltage_lockout = 1'b1;
    marks_invalid        = 0;
  end

  task automatic power(input logic lockout);
    @(posedge sys_clk);
    undervoltage_lockout <= lockout;
  endtask

  // sample the signature mid-cycle at the end of each mark step, after the sync lag
  task automatic hold_line(input logic cls, input logic mark, input int n);
    @(posedge sys_clk);
    line_above_class <= cls;
    line_below_mark  <= mark;
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    if (mark && invalid_signature === 1'b1) begin
      marks_invalid <= marks_invalid + 1;
    end
  endtask

  task automatic two_event();
    hold_line(1'b1, 1'b0, 10);
    hold_line(1'b0, 1'b1, 10);
    hold_line(1'b1, 1'b0, 10);
    hold_line(1'b0, 1'b1, 10);
    hold_line(1'b0, 1'b0, 10);
  endtask
endmodule

// >>> pdhs_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser per bit
module pdhs_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// >>> pdhs_top.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pdhs_consts.svh"

module pdhs_top
  import pdhs_pkg::*;
#(
  parameter int INRUSH_CYC = `PDHS_INRUSH_CYC,
  parameter int SHORT_CYC  = `PDHS_SHORT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        undervoltage_lockout,
  input  wire logic        detect_class_done,
  input  wire logic        line_above_class,
  input  wire logic        line_below_mark,
  input  wire logic        line_above_prot,
  input  wire logic        sw_below_on_thr,
  input  wire logic        sw_above_ovl_thr,
  input  wire logic        sw_above_off_thr,
  input  wire logic        sw_current_low,
  input  wire logic        avg_current_low,
  input  wire logic        avg_current_over,
  input  wire logic        error_amp_output,
  input  wire logic        ext_gate_sensed,
  input  wire logic        load_light,
  output logic             hotswap_switch_en,
  output logic             hotswap_limit_low,
  output logic             hotswap_full_on,
  output logic             invalid_signature,
  output logic             high_power_available_n,
  output logic             mps_pulse_en,
  output logic             sync_drv_en,
  output logic             ext_hotswap_gate,
  output logic             conv_reset,
  output logic             softstart_active,
  output logic             surge_clamp_en
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam int NIN = 14;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;

  assign raw_in = {load_light, ext_gate_sensed, error_amp_output, avg_current_over,
                   avg_current_low, sw_current_low, sw_above_off_thr, sw_above_ovl_thr,
                   sw_below_on_thr, line_above_prot, line_below_mark, line_above_class,
                   detect_class_done, undervoltage_lockout};

  pdhs_sync #(.W(NIN)) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .d       (raw_in),
    .q       (syn)
  );

  logic undervoltage_lockout_s, dc_done_s, cls_s, mark_s, prot_s, sw_lo_s, sw_ovl_s, sw_off_s;
  logic isw_lo_s, avg_lo_s, avg_oc_s, ea_hi_s, extg_s, light_s;
  assign {light_s, extg_s, ea_hi_s, avg_oc_s, avg_lo_s, isw_lo_s, sw_off_s, sw_ovl_s,
          sw_lo_s, prot_s, mark_s, cls_s, dc_done_s, undervoltage_lockout_s} = syn;

  // synced levels read as zero until the pipe refills after reset;
  // lockout would look released and the strap would be caught wrong
  logic [1:0] warm_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) warm_q <= '0;
    else         warm_q <= {warm_q[0], 1'b1};
  end

  // ************************************************************
  // register bus
  // ************************************************************
  logic [31:0] ctrl_q;
  logic [15:0] wait_cyc_q;
  logic        wr_en;
  logic        addr_ok;

  assign addr_ok = (paddr == `PDHS_ADDR_CTRL) || (paddr == `PDHS_ADDR_STATUS)
                || (paddr == `PDHS_ADDR_WAIT);
  assign wr_en   = psel && penable && pwrite && addr_ok;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q     <= `PDHS_CTRL_RST;
      wait_cyc_q <= 16'(`PDHS_WAIT_CYC_DEF);
    end else if (wr_en) begin
      if (paddr == `PDHS_ADDR_CTRL) ctrl_q <= {30'h0, pwdata[1:0]};
      if (paddr == `PDHS_ADDR_WAIT) wait_cyc_q <= pwdata[15:0];
    end
  end

  // ************************************************************
  // hotswap state machine
  // ************************************************************
  pdhs_state_t state_q, state_d;
  pdhs_class_t cls_q;
  logic [`PDHS_CNT_W-1:0] dwell_q;
  logic [`PDHS_CNT_W-1:0] qual_q;
  logic        two_event;
  logic        dwell_80;
  logic        ovl_qual;
  logic        wait_done;

  assign two_event = (cls_q == PDHS_CL_DONE);
  assign dwell_80  = dwell_q >= `PDHS_CNT_W'(INRUSH_CYC - 1);
  assign ovl_qual  = qual_q >= `PDHS_CNT_W'(`PDHS_OVL_QUAL_CYC - 1);
  assign wait_done = dwell_q >= `PDHS_CNT_W'(wait_cyc_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PDHS_OFF:
        if (warm_q[1] && !undervoltage_lockout_s && dc_done_s) state_d = PDHS_INRUSH;
      PDHS_INRUSH:
        if (sw_lo_s && (!two_event || dwell_80)) state_d = PDHS_ON;
      PDHS_ON:
        if (sw_ovl_s && ovl_qual) state_d = PDHS_OVERLOAD;
      PDHS_OVERLOAD:
        if (sw_lo_s && dwell_80 && wait_done) state_d = PDHS_ON;
    endcase
    if (undervoltage_lockout_s || sw_off_s) state_d = PDHS_OFF;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) state_q <= PDHS_OFF;
    else         state_q <= state_d;
  end

  // dwell in state; restarted on every change
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)                 dwell_q <= '0;
    else if (state_d != state_q) dwell_q <= '0;
    else if (!(&dwell_q))        dwell_q <= dwell_q + 1'b1;
  end

  // continuous over-threshold time in on state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)                                     qual_q <= '0;
    else if (state_q != PDHS_ON || !sw_ovl_s)        qual_q <= '0;
    else if (state_d != state_q)                     qual_q <= '0;
    else if (!ovl_qual)                              qual_q <= qual_q + 1'b1;
  end

  // ************************************************************
  // two-event classification
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cls_q <= PDHS_CL_IDLE;
    end else if (undervoltage_lockout_s && state_q != PDHS_OFF) begin
      cls_q <= PDHS_CL_IDLE;
    end else if (state_q == PDHS_OFF) begin
      unique case (cls_q)
        PDHS_CL_IDLE:  if (cls_s)  cls_q <= PDHS_CL_EV1;
        PDHS_CL_EV1:   if (mark_s) cls_q <= PDHS_CL_MARK1;
        PDHS_CL_MARK1: if (cls_s)  cls_q <= PDHS_CL_EV2;
        PDHS_CL_EV2:   if (mark_s) cls_q <= PDHS_CL_MARK2;
        PDHS_CL_MARK2: if (!mark_s && !cls_s) cls_q <= PDHS_CL_DONE;
        PDHS_CL_DONE:  cls_q <= PDHS_CL_DONE;
        default:       cls_q <= PDHS_CL_IDLE;
      endcase
    end
  end

  // ************************************************************
  // converter supervision and soft start
  // ************************************************************
  logic [`PDHS_CNT_W-1:0] ea_cnt_q;
  logic [`PDHS_SS_W-1:0]  ss_cnt_q;
  logic                   short_hit;
  logic                   conv_hold;
  logic                   ext_ok_q;
  logic                   ext_sampled_q;

  assign short_hit = ea_cnt_q >= `PDHS_CNT_W'(SHORT_CYC);
  assign conv_hold = state_q != PDHS_ON || avg_oc_s || short_hit;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)                     ea_cnt_q <= '0;
    else if (!ea_hi_s || short_hit)  ea_cnt_q <= '0;
    else if (softstart_active)       ea_cnt_q <= '0;
    else                             ea_cnt_q <= ea_cnt_q + 1'b1;
  end

  // soft start length adapts: light load ends it early
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)        ss_cnt_q <= '0;
    else if (conv_hold) ss_cnt_q <= '0;
    else if (ss_cnt_q < `PDHS_SS_W'(`PDHS_SOFTSTART_MAX)) begin
      if (light_s && ss_cnt_q >= `PDHS_SS_W'(`PDHS_SOFTSTART_MIN))
        ss_cnt_q <= `PDHS_SS_W'(`PDHS_SOFTSTART_MAX);
      else
        ss_cnt_q <= ss_cnt_q + 1'b1;
    end
  end

  // strap is caught once, after reset release, before first turn-on
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_ok_q      <= 1'b0;
      ext_sampled_q <= 1'b0;
    end else if (!ext_sampled_q && state_q == PDHS_OFF && !undervoltage_lockout_s && warm_q[1]) begin
      ext_ok_q      <= extg_s;
      ext_sampled_q <= 1'b1;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hotswap_switch_en      <= 1'b0;
      hotswap_limit_low      <= 1'b0;
      hotswap_full_on        <= 1'b0;
      invalid_signature      <= 1'b0;
      high_power_available_n <= 1'b1;
      mps_pulse_en           <= 1'b0;
      sync_drv_en            <= 1'b0;
      ext_hotswap_gate       <= 1'b0;
      conv_reset             <= 1'b1;
      softstart_active       <= 1'b0;
      surge_clamp_en         <= 1'b0;
    end else begin
      hotswap_switch_en      <= state_d != PDHS_OFF;
      hotswap_limit_low      <= state_d == PDHS_OVERLOAD;
      hotswap_full_on        <= state_d == PDHS_ON;
      invalid_signature      <= state_d == PDHS_OFF &&
                                (cls_q == PDHS_CL_EV1 || cls_q == PDHS_CL_EV2 ||
                                 cls_q == PDHS_CL_MARK1 || cls_q == PDHS_CL_MARK2)
                                && mark_s;
      high_power_available_n <= !two_event;
      mps_pulse_en           <= (state_d == PDHS_ON && isw_lo_s &&
                                 ctrl_q[`PDHS_CTRL_AUTO_SLEEP])
                                || (state_d != PDHS_OFF && ctrl_q[`PDHS_CTRL_FORCE_MPS]);
      sync_drv_en            <= !avg_lo_s && !conv_hold;
      ext_hotswap_gate       <= ext_ok_q && !avg_lo_s && state_d == PDHS_ON;
      conv_reset             <= conv_hold;
      softstart_active       <= !conv_hold && ss_cnt_q < `PDHS_SS_W'(`PDHS_SOFTSTART_MAX);
      surge_clamp_en         <= prot_s && state_d == PDHS_OFF;
    end
  end

  // apb: zero wait states
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        if (paddr == `PDHS_ADDR_CTRL)   prdata <= ctrl_q;
        if (paddr == `PDHS_ADDR_STATUS)
          prdata <= {24'h0, ext_ok_q, cls_q, state_q, !high_power_available_n, conv_reset};
        if (paddr == `PDHS_ADDR_WAIT)   prdata <= {16'h0, wait_cyc_q};
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_undervoltage_lockout;
    undervoltage_lockout_s;
  endsequence

  a_undervoltage_lockout_forces_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_undervoltage_lockout |=> state_q == PDHS_OFF && !hotswap_switch_en)
    else $error("switch not off under lockout");
  a_enter_inrush: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == PDHS_OFF && state_d != PDHS_OFF |-> state_d == PDHS_INRUSH)
    else $error("turn-on skipped inrush");
  a_inrush_quick_on: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == PDHS_INRUSH && sw_lo_s && !two_event && !undervoltage_lockout_s && !sw_off_s
      |=> state_q == PDHS_ON)
    else $error("single event inrush did not end");
  a_inrush_min_time: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == PDHS_INRUSH && two_event && state_d == PDHS_ON
      |-> dwell_q >= `PDHS_CNT_W'(INRUSH_CYC - 1))
    else $error("two event inrush too short");
  a_ovl_needs_qual: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(state_q == PDHS_OVERLOAD) |-> $past(sw_ovl_s) && $past(ovl_qual))
    else $error("overload entered early");
  a_ovl_return: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == PDHS_OVERLOAD ##1 state_q == PDHS_ON |-> $past(dwell_80) && $past(sw_lo_s))
    else $error("overload left early");
  a_switch_off_thr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sw_off_s |=> !hotswap_switch_en)
    else $error("switch not opened over threshold");
  a_surge_clamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
    surge_clamp_en |-> state_q == PDHS_OFF)
    else $error("surge clamp with switch on");
  a_oc_resets: assert property (@(posedge sys_clk) disable iff (!arst_n)
    avg_oc_s |=> conv_reset)
    else $error("overcurrent did not reset converter");
  a_hp_indication: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !high_power_available_n |-> $past(cls_q) == PDHS_CL_DONE)
    else $error("high power shown without sequence");
  a_low_current: assert property (@(posedge sys_clk) disable iff (!arst_n)
    avg_lo_s |=> !sync_drv_en && !ext_hotswap_gate)
    else $error("drivers on at low current");
  a_ovl_wait: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == PDHS_OVERLOAD ##1 state_q == PDHS_ON |-> $past(wait_done))
    else $error("overload left before wait expired");
  a_short_resets: assert property (@(posedge sys_clk) disable iff (!arst_n)
    short_hit |=> conv_reset && !softstart_active)
    else $error("output short did not reset converter");
  a_mps_auto: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_d == PDHS_ON && isw_lo_s && ctrl_q[`PDHS_CTRL_AUTO_SLEEP] |=> mps_pulse_en)
    else $error("no mps pulses at low current");
  a_strap_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ext_hotswap_gate |-> ext_ok_q)
    else $error("external gate driven without strap");
endmodule

// >>> poe_pd_hotswap_sequencer_test.sv
`timescale 1ns/1ps
module poe_pd_hotswap_sequencer_test;
  import pdhs_pkg::*;
  localparam int B_EN = 0, B_LOW = 1, B_FULL = 2, B_INV = 3, B_HPN = 4, B_MPS = 5;
  localparam int B_SYNC = 6, B_EXT = 7, B_CR = 8, B_SS = 9, B_SURGE = 10;
  logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        uvl, dcd, lac, lbm, prot, sw_on, sw_ovl, sw_off, sw_il;
  logic        avg_low, avg_over, eamp, ext_s, light;
  wire  [10:0] obs;
  int          bad_count, compares, marks;

  // ************************************
  // clock, parts
  // ************************************
  always #5 sys_clk = ~sys_clk;

  pdhs_pse u_pse (.sys_clk(sys_clk), .invalid_signature(obs[B_INV]), .line_above_class(lac),
    .line_below_mark(lbm), .undervoltage_lockout(uvl), .marks_invalid(marks));

  pdhs_top #(.INRUSH_CYC(200), .SHORT_CYC(50)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .undervoltage_lockout(uvl),
    .detect_class_done(dcd), .line_above_class(lac), .line_below_mark(lbm),
    .line_above_prot(prot), .sw_below_on_thr(sw_on), .sw_above_ovl_thr(sw_ovl),
    .sw_above_off_thr(sw_off), .sw_current_low(sw_il), .avg_current_low(avg_low),
    .avg_current_over(avg_over), .error_amp_output(eamp), .ext_gate_sensed(ext_s),
    .load_light(light), .hotswap_switch_en(obs[B_EN]), .hotswap_limit_low(obs[B_LOW]),
    .hotswap_full_on(obs[B_FULL]), .invalid_signature(obs[B_INV]),
    .high_power_available_n(obs[B_HPN]), .mps_pulse_en(obs[B_MPS]), .sync_drv_en(obs[B_SYNC]),
    .ext_hotswap_gate(obs[B_EXT]), .conv_reset(obs[B_CR]), .softstart_active(obs[B_SS]),
    .surge_clamp_en(obs[B_SURGE]));

  // ************************************
  // shared tasks
  // ************************************
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  // bounded wait; running out of the bound ends the run
  task automatic wait_bit(input int idx, input logic val, input int lim, input string what);
    int i;
    i = 0;
    @(negedge sys_clk);
    while (obs[idx] !== val && i < lim) begin
      @(negedge sys_clk);
      i++;
    end
    check(32'(obs[idx]), 32'(val), what);
    if (obs[idx] !== val) final_report();
  endtask

  task automatic hold_chk(input int idx, input logic val, input int n, input string what);
    repeat (n) @(negedge sys_clk);
    check(32'(obs[idx]), 32'(val), what);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    @(posedge sys_clk);
    while (pready !== 1'b1 && i < 20) begin
      @(posedge sys_clk);
      i++;
    end
    // read before the edge's updates land: the values that stood at it
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check(32'h0, 32'h1, "apb no answer");
      final_report();
    end
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset();
    @(negedge sys_clk);
    check(32'(obs), 32'h110, "reset outputs");
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0000_03e8, "wait reset");
    apb(1'b0, 12'h00c, 32'h0);
    check(32'(er), 32'h1, "unmapped error");
    $display("test reset done");
  endtask

  task automatic t_single();
    prot <= 1'b1;
    wait_bit(B_SURGE, 1'b1, 10, "clamp while off");
    prot <= 1'b0;
    u_pse.power(1'b0);
    hold_chk(B_EN, 1'b0, 10, "no turn-on before class done");
    dcd  <= 1'b1;
    wait_bit(B_EN, 1'b1, 10, "switch enabled");
    hold_chk(B_FULL, 1'b0, 20, "inrush current limited");
    sw_on <= 1'b1;
    wait_bit(B_FULL, 1'b1, 8, "single event on at once");
    check(32'(obs[B_HPN]), 32'h1, "no high power");
    prot <= 1'b1;
    hold_chk(B_SURGE, 1'b0, 10, "no clamp while on");
    prot <= 1'b0;
    $display("test single done");
  endtask

  task automatic t_conv();
    wait_bit(B_CR, 1'b0, 5000, "converter released");
    wait_bit(B_SS, 1'b0, 5000, "soft start ends");
    sw_il <= 1'b1;
    hold_chk(B_MPS, 1'b0, 10, "no mps without auto sleep");
    apb(1'b1, 12'h000, 32'h1);
    wait_bit(B_MPS, 1'b1, 10, "mps on low current");
    sw_il   <= 1'b0;
    avg_low <= 1'b1;
    wait_bit(B_SYNC, 1'b0, 10, "sync off");
    check(32'(obs[B_EXT]), 32'h0, "ext gate off");
    avg_low <= 1'b0;
    wait_bit(B_EXT, 1'b1, 5000, "ext gate strap");
    avg_over <= 1'b1;
    wait_bit(B_CR, 1'b1, 10, "overcurrent reset");
    hold_chk(B_CR, 1'b1, 20, "reset held");
    avg_over <= 1'b0;
    wait_bit(B_CR, 1'b0, 10, "overcurrent cleared");
    wait_bit(B_SS, 1'b1, 5, "restart soft");
    wait_bit(B_SS, 1'b0, 5000, "soft start ends");
    eamp <= 1'b1;
    hold_chk(B_CR, 1'b0, 40, "short not yet");
    wait_bit(B_CR, 1'b1, 40, "short resets");
    eamp <= 1'b0;
    sw_off <= 1'b1;
    wait_bit(B_EN, 1'b0, 10, "off threshold opens");
    sw_off <= 1'b0;
    $display("test converter done");
  endtask

  task automatic t_two();
    dcd <= 1'b0;
    u_pse.power(1'b1);
    wait_bit(B_EN, 1'b0, 10, "lockout off");
    u_pse.two_event();
    check(32'(marks), 32'h2, "invalid signature in marks");
    wait_bit(B_HPN, 1'b0, 10, "high power indicated");
    check(32'(obs[B_INV]), 32'h0, "valid signature after marks");
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0000_00f3, "status after two event");
    dcd <= 1'b1;
    u_pse.power(1'b0);
    wait_bit(B_EN, 1'b1, 10, "two event inrush");
    hold_chk(B_FULL, 1'b0, 100, "dwell not over");
    wait_bit(B_FULL, 1'b1, 150, "two event on");
    $display("test two event done");
  endtask

  task automatic t_ovl();
    sw_on  <= 1'b0;
    sw_ovl <= 1'b1;
    hold_chk(B_LOW, 1'b0, 10000, "short overload");
    sw_ovl <= 1'b0;
    repeat (5) @(posedge sys_clk);
    sw_ovl <= 1'b1;
    hold_chk(B_LOW, 1'b0, 13000, "qual restarted");
    wait_bit(B_LOW, 1'b1, 1100, "overload entered");
    apb(1'b1, 12'h008, 32'h190);
    sw_ovl <= 1'b0;
    sw_on  <= 1'b1;
    hold_chk(B_LOW, 1'b1, 100, "overload dwell");
    hold_chk(B_LOW, 1'b1, 200, "wait not expired");
    wait_bit(B_FULL, 1'b1, 150, "back on after wait");
    u_pse.power(1'b1);
    wait_bit(B_EN, 1'b0, 10, "lockout opens");
    wait_bit(B_HPN, 1'b1, 10, "high power cleared");
    $display("test overload done");
  endtask

  // mid-run reset, strap tied off, heavy load: full soft start
  task automatic t_strap();
    ext_s  <= 1'b0;
    light  <= 1'b0;
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(32'(obs), 32'h110, "mid-run reset outputs");
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0, "ctrl cleared by reset");
    u_pse.power(1'b0);
    wait_bit(B_EN, 1'b1, 10, "restart after reset");
    wait_bit(B_CR, 1'b0, 50, "converter released again");
    hold_chk(B_SS, 1'b1, 1000, "full soft start at heavy load");
    wait_bit(B_SS, 1'b0, 4000, "heavy soft start ends");
    check(32'(obs[B_EXT]), 32'h0, "no ext gate when strapped off");
    check(32'(obs[B_SYNC]), 32'h1, "sync on at normal current");
    $display("test strap done");
  endtask

  initial begin
    {sys_clk, arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {dcd, prot, sw_on, sw_ovl, sw_off, sw_il, avg_low, avg_over, eamp} = '0;
    ext_s = 1'b1;
    light = 1'b1;
    bad_count = 0;
    compares = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_single();
    t_conv();
    t_two();
    t_ovl();
    t_strap();
    final_report();
  end
endmodule
